// ---- verilog/rvl_pkg.sv ----
// Operation
// RULE1 - Power-on/brown-out, the master-clear/watchdog/reset-instruction/stack group, and sleep wake-up are three separate load classes.
// RULE2 - An interrupt wake-up with either global enable set loads the program counter with vector 0008h or 0018h.
// RULE3 - On that wake-up the current program counter is copied into the three top-of-stack bytes.
// RULE4 - On that wake-up the return stack pointer advances to the next hardware stack entry.
// RULE5 - Any wake-up from sleep sets a flag that names its source in the interrupt flag register.
// RULE6 - The long-write enable is cleared only by power-on or master-clear reset and survives every other cause.
// RULE7 - Port A bit 6 with its latch and direction bits works only in the external-clock and RC I/O modes, else reads zero.
// RULE8 - On variants without port A bit 6 those bits read zero in port, latch and direction.
// RULE9 - Unimplemented bits read zero and bits marked unchanged keep their contents through the class.
// RULE10 - Each register loads its listed pattern for the active class; unknown bits load zero here.
package rvl_pkg;
	localparam int NSFR = 24;
	localparam int PCW = 21;
	localparam int SPW = 5;
	localparam logic [4:0] IDX_CAUSE = 5'h0c;
	localparam logic [4:0] IDX_T2_PERIOD = 5'h11;
	localparam int BIT_LONG_WR = 6;
	localparam int BIT_INSTR = 4;
	localparam int BIT_TIMEOUT = 3;
	localparam int BIT_PWR_DOWN = 2;
	// Tables are listed from index 23 down to index 0.
	localparam logic [NSFR-1:0][7:0] SFR_IMPL = {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff,
		8'hbf, 8'hff, 8'hff, 8'hdf, 8'h01, 8'h3f, 8'h01, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h0f, 8'h0f,
		8'hff, 8'h0f};
	localparam logic [NSFR-1:0][7:0] SFR_POR = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h1c, 8'h00, 8'h05, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};
	localparam logic [NSFR-1:0][7:0] SFR_B_KEEP = {8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff,
		8'hbf, 8'hff, 8'hff, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h00, 8'h00,
		8'hff, 8'h00};
	localparam logic [NSFR-1:0][7:0] SFR_C_KEEP = {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hf3, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff};
	localparam logic [11:0] ADDR_GIE = 12'h060;
	localparam logic [11:0] ADDR_STAT = 12'h064;
	localparam logic [11:0] ADDR_MASK = 12'h068;
	localparam logic [11:0] ADDR_PC = 12'h06c;
	localparam logic [11:0] ADDR_TOS = 12'h070;
	localparam logic [11:0] ADDR_STK = 12'h074;
	localparam logic [11:0] ADDR_PORT6 = 12'h078;
	localparam int ST_WDT_WAKE = 0;
	localparam int ST_INT_WAKE = 1;
	localparam int ST_CLASS_B = 2;
	localparam int ST_POR = 3;
	localparam logic [PCW-1:0] VEC_HIGH = 21'h000008;
	localparam logic [PCW-1:0] VEC_LOW = 21'h000018;
	localparam logic [PCW-1:0] PC_STEP = 21'h000002;
	localparam logic [2:0] OSC_EC_IO = 3'h5;
	localparam logic [2:0] OSC_RC_IO = 3'h7;
	typedef struct packed {
		logic por;
		logic master_clear;
		logic wdt;
		logic instr;
		logic stack;
		logic wdt_wake;
		logic int_wake;
		logic int_high;
	} rvl_cause_t;
	typedef struct packed {
		logic [NSFR-1:0][7:0] sfr;
		logic [1:0] gie;
		logic [3:0] stat;
		logic [3:0] mask;
		logic [PCW-1:0] pc_addr;
		logic pc_load;
		logic [PCW-1:0] tos;
		logic [SPW-1:0] stack_ptr;
		logic stkful;
		logic lat6;
		logic tris6;
		logic [31:0] prdata;
		logic pslverr;
	} rvl_state_t;
endpackage

// ---- verilog/rvl_sync2.sv ----
`timescale 1ns/1ps
module rvl_sync2 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic meta;
		logic stable;
	} rvl_sync_t;
	rvl_sync_t st_r;
	rvl_sync_t st_nxt;

	always_comb begin
		st_nxt.meta = d;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.stable;
endmodule

// ---- verilog/rvl_wake_calc.sv ----
`timescale 1ns/1ps
module rvl_wake_calc (
	input wire logic [rvl_pkg::SPW-1:0] stack_ptr,
	input wire logic int_high,
	input wire logic gie_high,
	output logic [rvl_pkg::PCW-1:0] vec_addr,
	output logic [rvl_pkg::SPW-1:0] stk_nxt,
	output logic stk_full
);
	// A high priority source only takes the high vector while its own enable is set.
	assign vec_addr = (int_high && gie_high) ? rvl_pkg::VEC_HIGH : rvl_pkg::VEC_LOW; // RULE2
	assign stk_nxt = stack_ptr + {{(rvl_pkg::SPW-1){1'b0}}, 1'b1}; // RULE4
	// Advancing from the last entry wraps the pointer, so the full flag records it.
	assign stk_full = &stack_ptr;
endmodule

// ---- verilog/rvl_loader.sv ----
`timescale 1ns/1ps
module rvl_loader #(
	parameter bit HAS_BIT6 = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rvl_pkg::rvl_cause_t cause,
	input wire logic [rvl_pkg::PCW-1:0] pc_cur,
	input wire logic [2:0] osc_mode,
	output logic pc_load,
	output logic [rvl_pkg::PCW-1:0] pc_load_addr,
	input wire logic porta6_in,
	output logic porta6_out,
	output logic porta6_oe_n,
	output logic irq
);
	rvl_pkg::rvl_state_t st_r;
	rvl_pkg::rvl_state_t st_nxt;
	logic por_now;
	logic b_now;
	logic c_now;
	logic vec_go;
	logic bit6_en;
	logic pin6_sync;
	logic [rvl_pkg::PCW-1:0] vec_addr;
	logic [rvl_pkg::SPW-1:0] stk_nxt;
	logic stk_full;
	logic setup_ph;
	logic access_ph;
	logic [3:0] stat_set;
	logic [31:0] rd_data;
	logic rd_err;

	// Returns {hit, index} for an aligned word inside the table window.
	function automatic logic [5:0] sfr_decode(input logic [11:0] addr);
		logic [5:0] res;
		res = 6'h00;
		if (addr[1:0] == 2'h0 && addr[11:2] < 10'(rvl_pkg::NSFR)) begin
			res = {1'b1, addr[6:2]};
		end
		return res;
	endfunction

	rvl_sync2 u_pin6_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(porta6_in),
		.q(pin6_sync)
	);

	rvl_wake_calc u_wake_calc (
		.stack_ptr(st_r.stack_ptr),
		.int_high(cause.int_high),
		.gie_high(st_r.gie[1]),
		.vec_addr(vec_addr),
		.stk_nxt(stk_nxt),
		.stk_full(stk_full)
	);

	// Power-on wins over the reset group, which wins over a wake-up.
	assign por_now = cause.por; // RULE1
	assign b_now = !por_now && (cause.master_clear || cause.wdt || cause.instr || cause.stack); // RULE1
	assign c_now = !por_now && !b_now && (cause.wdt_wake || cause.int_wake); // RULE1
	assign vec_go = c_now && cause.int_wake && (st_r.gie != 2'h0);
	assign bit6_en = HAS_BIT6 && (osc_mode == rvl_pkg::OSC_EC_IO || osc_mode == rvl_pkg::OSC_RC_IO); // RULE7 RULE8
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;

	always_comb begin
		stat_set = 4'h0;
		stat_set[rvl_pkg::ST_POR] = por_now;
		stat_set[rvl_pkg::ST_CLASS_B] = b_now;
		stat_set[rvl_pkg::ST_WDT_WAKE] = c_now && cause.wdt_wake; // RULE5
		stat_set[rvl_pkg::ST_INT_WAKE] = c_now && cause.int_wake; // RULE5
	end

	always_comb begin
		logic [5:0] dec;
		dec = sfr_decode(paddr);
		rd_data = 32'h00000000;
		rd_err = 1'b0;
		if (dec[5]) begin
			rd_data[7:0] = st_r.sfr[dec[4:0]] & rvl_pkg::SFR_IMPL[dec[4:0]]; // RULE9
		end else if (paddr == rvl_pkg::ADDR_GIE) begin
			rd_data[7:6] = st_r.gie;
		end else if (paddr == rvl_pkg::ADDR_STAT) begin
			rd_data[3:0] = st_r.stat;
		end else if (paddr == rvl_pkg::ADDR_MASK) begin
			rd_data[3:0] = st_r.mask;
		end else if (paddr == rvl_pkg::ADDR_PC) begin
			rd_data[rvl_pkg::PCW-1:0] = st_r.pc_addr;
		end else if (paddr == rvl_pkg::ADDR_TOS) begin
			rd_data[rvl_pkg::PCW-1:0] = st_r.tos;
		end else if (paddr == rvl_pkg::ADDR_STK) begin
			rd_data[7:0] = {st_r.stkful, 2'h0, st_r.stack_ptr};
		end else if (paddr == rvl_pkg::ADDR_PORT6) begin
			// Disabled or absent, all three bit-6 views read zero.
			rd_data[2:0] = bit6_en ? {st_r.tris6, st_r.lat6, pin6_sync} : 3'h0; // RULE7 RULE8
		end else begin
			rd_err = 1'b1;
		end
	end

	always_comb begin
		logic [5:0] dec;
		dec = sfr_decode(paddr);
		st_nxt = st_r;
		st_nxt.pc_load = 1'b0;
		if (setup_ph) begin
			st_nxt.prdata = pwrite ? 32'h00000000 : rd_data;
			st_nxt.pslverr = rd_err;
		end
		if (access_ph && pwrite && !por_now && !b_now && !c_now) begin
			if (dec[5]) begin
				st_nxt.sfr[dec[4:0]] = pwdata[7:0] & rvl_pkg::SFR_IMPL[dec[4:0]]; // RULE9
			end else if (paddr == rvl_pkg::ADDR_GIE) begin
				st_nxt.gie = pwdata[7:6];
			end else if (paddr == rvl_pkg::ADDR_MASK) begin
				st_nxt.mask = pwdata[3:0];
			end else if (paddr == rvl_pkg::ADDR_STK) begin
				st_nxt.stack_ptr = pwdata[rvl_pkg::SPW-1:0];
				st_nxt.stkful = pwdata[7];
			end else if (paddr == rvl_pkg::ADDR_PORT6) begin
				st_nxt.lat6 = pwdata[1];
				st_nxt.tris6 = pwdata[2];
			end
		end
		// A read of the status clears it, but an event in the same cycle still lands.
		if (access_ph && !pwrite && paddr == rvl_pkg::ADDR_STAT) begin
			st_nxt.stat = 4'h0;
		end
		st_nxt.stat = st_nxt.stat | stat_set; // RULE5
		if (por_now) begin
			for (int i = 0; i < rvl_pkg::NSFR; i++) begin
				st_nxt.sfr[i] = rvl_pkg::SFR_POR[i]; // RULE10
			end
			st_nxt.gie = 2'h0;
			st_nxt.tos = '0;
			st_nxt.stack_ptr = '0;
			st_nxt.stkful = 1'b0;
			st_nxt.lat6 = 1'b0;
			st_nxt.tris6 = 1'b1;
			st_nxt.pc_addr = '0;
			st_nxt.pc_load = 1'b1;
		end else if (b_now) begin
			for (int i = 0; i < rvl_pkg::NSFR; i++) begin
				st_nxt.sfr[i] = (st_r.sfr[i] & rvl_pkg::SFR_B_KEEP[i]) |
					(rvl_pkg::SFR_POR[i] & ~rvl_pkg::SFR_B_KEEP[i]); // RULE9 RULE10
			end
			// Only a master clear takes the long-write enable down in this group.
			st_nxt.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_LONG_WR] =
				cause.master_clear ? 1'b0 : st_r.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_LONG_WR]; // RULE6
			st_nxt.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_INSTR] = !cause.instr;
			if (cause.wdt) begin
				st_nxt.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_TIMEOUT] = 1'b0;
				st_nxt.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_PWR_DOWN] = 1'b1;
			end else begin
				st_nxt.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_TIMEOUT] =
					st_r.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_TIMEOUT];
				st_nxt.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_PWR_DOWN] =
					st_r.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_PWR_DOWN];
			end
			st_nxt.gie = 2'h0;
			st_nxt.tos = '0;
			st_nxt.stack_ptr = '0;
			st_nxt.stkful = 1'b0;
			st_nxt.tris6 = 1'b1;
			st_nxt.pc_addr = '0;
			st_nxt.pc_load = 1'b1;
		end else if (c_now) begin
			for (int i = 0; i < rvl_pkg::NSFR; i++) begin
				st_nxt.sfr[i] = (st_r.sfr[i] & rvl_pkg::SFR_C_KEEP[i]) |
					(rvl_pkg::SFR_POR[i] & ~rvl_pkg::SFR_C_KEEP[i]); // RULE9 RULE10
			end
			// Time-out marks a watchdog wake, power-down is always cleared by a wake.
			st_nxt.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_TIMEOUT] = !cause.wdt_wake;
			st_nxt.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_PWR_DOWN] = 1'b0;
			st_nxt.pc_load = 1'b1;
			if (vec_go) begin
				st_nxt.pc_addr = vec_addr; // RULE2
				st_nxt.tos = pc_cur; // RULE3
				st_nxt.stack_ptr = stk_nxt; // RULE4
				st_nxt.stkful = st_r.stkful | stk_full; // RULE4
			end else begin
				st_nxt.pc_addr = pc_cur + rvl_pkg::PC_STEP;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.sfr <= rvl_pkg::SFR_POR; // RULE1 RULE10
			st_r.tris6 <= 1'b1;
			st_r.stat <= 4'h8;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Zero wait states: read data is captured in the setup cycle.
	assign pready = 1'b1;
	assign prdata = st_r.prdata;
	assign pslverr = st_r.pslverr;
	assign pc_load = st_r.pc_load;
	assign pc_load_addr = st_r.pc_addr;
	assign porta6_out = bit6_en && st_r.lat6; // RULE7
	assign porta6_oe_n = !(bit6_en && !st_r.tris6); // RULE7 RULE8
	assign irq = |(st_r.stat & st_r.mask);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_class_b_load: assert property (b_now |=> pc_load && pc_load_addr == '0 && st_r.stack_ptr == '0) // RULE1
		else $error("reset group did not clear pc and stack");
	a_int_vector: assert property (vec_go |=> // RULE2
		pc_load_addr == (($past(cause.int_high) && $past(st_r.gie[1])) ? rvl_pkg::VEC_HIGH : rvl_pkg::VEC_LOW))
		else $error("wrong interrupt vector after wake");
	a_tos_copy: assert property (vec_go |=> st_r.tos == $past(pc_cur)) // RULE3
		else $error("stack top not loaded from pc");
	a_stk_advance: assert property (vec_go |=> st_r.stack_ptr == $past(st_r.stack_ptr) + 5'h01) // RULE4
		else $error("stack pointer did not advance");
	a_wake_flag: assert property (c_now |=> (st_r.stat[rvl_pkg::ST_WDT_WAKE] || st_r.stat[rvl_pkg::ST_INT_WAKE])) // RULE5
		else $error("wake source flag missing");
	a_lwrt_hold: assert property (((b_now && !cause.master_clear) || c_now) |=> // RULE6
		$stable(st_r.sfr[rvl_pkg::IDX_CAUSE][rvl_pkg::BIT_LONG_WR]))
		else $error("long-write enable lost");
	a_bit6_zero: assert property (setup_ph && !pwrite && paddr == rvl_pkg::ADDR_PORT6 && !bit6_en |=> // RULE7
		prdata == 32'h00000000)
		else $error("disabled bit 6 did not read zero");
	a_unimpl_zero: assert property (setup_ph && !pwrite && sfr_decode(paddr) != 6'h00 |=> // RULE9
		prdata[31:8] == 24'h000000 && (prdata[7:0] & ~rvl_pkg::SFR_IMPL[$past(paddr[6:2])]) == 8'h00)
		else $error("unimplemented bit read nonzero");
	a_period_wake: assert property (c_now |=> st_r.sfr[rvl_pkg::IDX_T2_PERIOD] == 8'hff ##1 pc_load == 1'b0) // RULE10
		else $error("period register not reloaded on wake");
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pready2, pslverr2, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, prdata2, rd, rd2;
	rvl_pkg::rvl_cause_t cause;
	logic [rvl_pkg::PCW-1:0] pc_cur, pc_load_addr, pc_load_addr2;
	logic [2:0] osc_mode;
	logic pc_load, pc_load2, porta6_in, porta6_out, porta6_oe_n, irq, out2, oe_n2, irq2;
	int mismatches, n_compared;
	rvl_loader u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cause(cause),
		.pc_cur(pc_cur), .osc_mode(osc_mode), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
		.porta6_in(porta6_in), .porta6_out(porta6_out), .porta6_oe_n(porta6_oe_n), .irq(irq));
	// A variant without the bit 6 pin shares every input and is judged on its own outputs.
	rvl_loader #(.HAS_BIT6(1'b0)) u_dut_nopin (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata2), .pready(pready2), .pslverr(pslverr2),
		.cause(cause), .pc_cur(pc_cur), .osc_mode(osc_mode), .pc_load(pc_load2), .pc_load_addr(pc_load_addr2),
		.porta6_in(porta6_in), .porta6_out(out2), .porta6_oe_n(oe_n2), .irq(irq2));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Entered just after a rising edge; leaves one idle edge so the next call never reassigns psel in one step.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) chk(32'h0, 32'h1, "pready never came");
		rd = prdata;
		rd2 = prdata2;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd, e, m);
	endtask
	task pulse(input logic [7:0] c, input logic [20:0] pc, input logic [20:0] ea);
		cause <= rvl_pkg::rvl_cause_t'(c);
		pc_cur <= pc;
		@(posedge pclk);
		cause <= rvl_pkg::rvl_cause_t'(8'h00);
		#1;
		chk(32'(pc_load), 32'h1, "pc_load pulse");
		chk(32'(pc_load_addr), 32'(ea), "pc_load_addr");
		@(posedge pclk);
	endtask
	task automatic t_reset;
		logic [11:0] a [9] = '{12'h000, 12'h014, 12'h020, 12'h028, 12'h030, 12'h03c, 12'h044, 12'h064, 12'h074};
		logic [7:0] e [9] = '{8'h00, 8'h00, 8'hff, 8'h05, 8'h1c, 8'h00, 8'hff, 8'h08, 8'h00};
		chk(32'(irq), 32'h0, "irq after reset");
		for (int i = 0; i < 9; i++) rdc(a[i], 32'(e[i]), "power-on value");
		rdc(12'h064, 32'h0, "status read clears");
		$display("test reset values done");
	endtask
	task automatic t_rw;
		logic [11:0] a [7] = '{12'h000, 12'h008, 12'h014, 12'h024, 12'h03c, 12'h048, 12'h044};
		logic [7:0] e [7] = '{8'h0f, 8'h0f, 8'h1f, 8'h01, 8'hbf, 8'h7f, 8'hff};
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, a[i], 32'hffff_ffff);
			rdc(a[i], 32'(e[i]), "unimplemented bits");
			chk(32'(err), 32'h0, "mapped error");
		end
		apb(1'b1, 12'h07c, 32'h1);
		chk(32'(err), 32'h1, "unmapped write");
		apb(1'b0, 12'hffc, 32'h0);
		chk(32'(err), 32'h1, "unmapped read");
		apb(1'b1, 12'h064, 32'hf);
		rdc(12'h064, 32'h0, "status is read-only");
		$display("test register access done");
	endtask
	task cls(input logic [7:0] c, e3c, e48, e00, ercon, mrcon, est, input logic [20:0] ea);
		apb(1'b1, 12'h03c, 32'hff);
		apb(1'b1, 12'h048, 32'hff);
		apb(1'b1, 12'h044, 32'h12);
		apb(1'b1, 12'h000, 32'hff);
		apb(1'b1, 12'h030, 32'h5c);
		apb(1'b0, 12'h064, 32'h0);
		pulse(c, 21'h000100, ea);
		chk(32'(irq), 32'h0, "masked event");
		rdc(12'h03c, 32'(e3c), "kept or loaded");
		rdc(12'h048, 32'(e48), "cleared by class");
		rdc(12'h044, 32'hff, "period forced");
		rdc(12'h000, 32'(e00), "pointer class");
		apb(1'b0, 12'h030, 32'h0);
		chk(rd & 32'(mrcon), 32'(ercon), "long write and flags");
		rdc(12'h064, 32'(est), "source flag");
	endtask
	task t_cls;
		cls(8'h04, 8'hbf, 8'h7f, 8'h0f, 8'h40, 8'h4c, 8'h01, 21'h000102);
		cls(8'h20, 8'hbf, 8'h00, 8'h00, 8'h44, 8'h4c, 8'h04, 21'h0);
		cls(8'h10, 8'hbf, 8'h00, 8'h00, 8'h40, 8'h40, 8'h04, 21'h0);
		cls(8'h08, 8'hbf, 8'h00, 8'h00, 8'h40, 8'h40, 8'h04, 21'h0);
		cls(8'h40, 8'hbf, 8'h00, 8'h00, 8'h00, 8'h40, 8'h04, 21'h0);
		cls(8'h80, 8'h00, 8'h00, 8'h00, 8'h1c, 8'hff, 8'h08, 21'h0);
		$display("test reset classes done");
	endtask
	task wk(input logic [7:0] g, input logic hi, input logic [20:0] pc, ea, et, input logic [4:0] es);
		apb(1'b1, 12'h060, 32'(g));
		apb(1'b1, 12'h068, 32'h2);
		apb(1'b0, 12'h064, 32'h0);
		pulse({6'h00, 1'b1, hi}, pc, ea);
		chk(32'(irq), 32'h1, "irq on wake");
		rdc(12'h070, 32'(et), "top of stack");
		apb(1'b0, 12'h074, 32'h0);
		chk(rd & 32'h1f, 32'(es), "stack pointer");
		rdc(12'h064, 32'h2, "interrupt wake flag");
		chk(32'(irq), 32'h0, "irq after clear");
	endtask
	task t_wake;
		wk(8'h80, 1'b1, 21'h012345, 21'h000008, 21'h012345, 5'h01);
		wk(8'h40, 1'b0, 21'h0abcde, 21'h000018, 21'h0abcde, 5'h02);
		wk(8'h00, 1'b1, 21'h000100, 21'h000102, 21'h0abcde, 5'h02);
		apb(1'b1, 12'h074, 32'h1f);
		wk(8'h40, 1'b0, 21'h000200, 21'h000018, 21'h000200, 5'h00);
		apb(1'b0, 12'h074, 32'h0);
		chk(rd, 32'h80, "stack full on wrap");
		rdc(12'h06c, 32'h18, "last load address");
		$display("test interrupt wake done");
	endtask
	task t_port;
		osc_mode <= 3'h5;
		porta6_in <= 1'b1;
		apb(1'b1, 12'h078, 32'h2);
		chk(32'(porta6_oe_n), 32'h0, "pin driven");
		chk(32'(porta6_out), 32'h1, "pin level");
		chk(32'(oe_n2), 32'h1, "absent pin idle");
		chk(32'(out2), 32'h0, "absent pin low");
		repeat (3) @(posedge pclk);
		rdc(12'h078, 32'h3, "pin readback");
		chk(rd2, 32'h0, "absent pin reads zero");
		osc_mode <= 3'h0;
		rdc(12'h078, 32'h0, "disabled mode reads zero");
		chk(32'(porta6_oe_n), 32'h1, "disabled pin released");
		osc_mode <= 3'h7;
		apb(1'b1, 12'h078, 32'h2);
		repeat (3) @(posedge pclk);
		rdc(12'h078, 32'h3, "rc mode readback");
		$display("test bit six done");
	endtask
	task results;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		results;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cause = rvl_pkg::rvl_cause_t'(8'h00);
		pc_cur = 21'h0;
		osc_mode = 3'h0;
		porta6_in = 1'b0;
		mismatches = 0;
		n_compared = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_rw;
		t_cls;
		t_wake;
		t_port;
		results;
	end
endmodule
